/* File: src/spi_pkg.sv */
`default_nettype none
package spi_pkg;
	// register addresses
	localparam logic [15:0] OFS_DATA = 16'h0011;
	localparam logic [15:0] OFS_CTRL = 16'h0012;
	localparam logic [15:0] OFS_CSR  = 16'h0013;
	// serial_control fields
	localparam int B_IRQEN = 7;
	localparam int B_EN    = 6;
	localparam int B_R2    = 5;
	localparam int B_MASTER_SELECT  = 4;
	localparam int B_CLOCK_IDLE_LEVEL  = 3;
	localparam int B_CLOCK_CAPTURE_PHASE  = 2;
	localparam int B_R1    = 1;
	localparam int B_R0    = 0;
	// serial_control_status fields
	localparam int B_DONE = 7;
	localparam int B_WRITE_COLLISION_FLAG = 6;
	localparam int B_OVR  = 5;
	localparam int B_MODE_FAULT_FLAG = 4;
	localparam int B_ODIS = 2;
	localparam int B_SSM  = 1;
	localparam int B_SSI  = 0;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [2:0] CSR_RST  = 3'h0;
	localparam logic [7:0] DATA_RST = 8'h00;
	// rate codes {rate_bit2,rate_bit1,rate_bit0}
	localparam logic [2:0] RATE_DIV4   = 3'h4;
	localparam logic [2:0] RATE_DIV8   = 3'h0;
	localparam logic [2:0] RATE_DIV16  = 3'h1;
	localparam logic [2:0] RATE_DIV32  = 3'h6;
	localparam logic [2:0] RATE_DIV64  = 3'h2;
	localparam logic [2:0] RATE_DIV128 = 3'h3;
	// half sck periods in clk cycles
	localparam logic [6:0] HALF_DIV4   = 7'h02;
	localparam logic [6:0] HALF_DIV8   = 7'h04;
	localparam logic [6:0] HALF_DIV16  = 7'h08;
	localparam logic [6:0] HALF_DIV32  = 7'h10;
	localparam logic [6:0] HALF_DIV64  = 7'h20;
	localparam logic [6:0] HALF_DIV128 = 7'h40;
	// sixteen sck edges per byte, numbered 0..15
	localparam logic [3:0] LAST_EDGE = 4'hF;
endpackage
`default_nettype wire

/* File: src/spi_regif.sv */
// Contract
// - irq when enabled and done/fault/overrun set
// - enable resets low, cleared by mode fault
// - master select cleared by mode fault
// - rate bits pick sck divider in master
// - rate bits ignored in slave mode
// - polarity sets sck idle level
// - phase picks first or second capture edge
// - done set at end, status-then-data clears
// - data writes ignored while done unacknowledged
// - collision flag on data write mid-transfer
// - overrun on completion with done set
// - fault on select low in master
// - output disable removes data output drive
// - soft select source frees select pin
// - soft select level: zero means selected
// - master data write starts a byte
// - received byte copied to read buffer
// - data write loads shift register directly
// - control and status reset to zero
// - fault blocks setting enable and master
// - overrun keeps first byte, drops later
`default_nettype none
module spi_regif
	import spi_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// register port
	input  wire logic [15:0] addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [7:0]  rdata,
	// interrupt request
	output logic             irq,
	// serial clock pin
	input  wire logic        sck_in,
	output logic             sck_out,
	output logic             sck_oe_n,
	// master-out data pin
	input  wire logic        mosi_in,
	output logic             mosi_out,
	output logic             mosi_oe_n,
	// master-in data pin
	input  wire logic        miso_in,
	output logic             miso_out,
	output logic             miso_oe_n,
	// slave select pin
	input  wire logic        ss_n_in
);

	logic [7:0] ctrl_q, ctrl_d;
	logic [2:0] cfg_q, cfg_d;
	logic       done_q, done_d;
	logic       write_collision_flag_q, write_collision_flag_d;
	logic       ovr_q, ovr_d;
	logic       mode_fault_flag_q, mode_fault_flag_d;
	logic       arm_q, arm_d;
	logic       marm_q, marm_d;
	logic [7:0] sh_q, sh_d;
	logic       out_q, out_d;
	logic [7:0] rxbuf_q;
	logic [3:0] cnt_q, cnt_d;
	logic       busy_q, busy_d;
	logic       phase_q;
	logic [6:0] div_q;
	logic [3:0] s1_q, s2_q;
	logic       sck_s3_q;

	function automatic logic [6:0] half_of(input logic [2:0] r);
		unique case (r)
			RATE_DIV4:   half_of = HALF_DIV4;
			RATE_DIV8:   half_of = HALF_DIV8;
			RATE_DIV16:  half_of = HALF_DIV16;
			RATE_DIV32:  half_of = HALF_DIV32;
			RATE_DIV64:  half_of = HALF_DIV64;
			RATE_DIV128: half_of = HALF_DIV128;
			// unlisted codes fall back to the slowest rate
			default:     half_of = HALF_DIV128;
		endcase
	endfunction

	// synchronised pins: 0 sck, 1 mosi, 2 miso, 3 select
	wire sck_s  = s2_q[0];
	wire mosi_s = s2_q[1];
	wire miso_s = s2_q[2];
	wire ss_s   = s2_q[3];

	wire       irq_en = ctrl_q[B_IRQEN];
	wire       en     = ctrl_q[B_EN];
	wire       master_select   = ctrl_q[B_MASTER_SELECT];
	wire       clock_idle_level   = ctrl_q[B_CLOCK_IDLE_LEVEL];
	wire       clock_capture_phase   = ctrl_q[B_CLOCK_CAPTURE_PHASE];
	wire [2:0] rate   = {ctrl_q[B_R2], ctrl_q[B_R1], ctrl_q[B_R0]};
	wire       odis   = cfg_q[B_ODIS];
	wire       select_source_soft    = cfg_q[B_SSM];
	wire       soft_select_level    = cfg_q[B_SSI];

	wire hit_data = addr == OFS_DATA;
	wire hit_ctrl = addr == OFS_CTRL;
	wire hit_csr  = addr == OFS_CSR;
	wire wr_data  = wr && hit_data;
	wire rd_data  = rd && hit_data;
	wire wr_ctrl  = wr && hit_ctrl;
	wire wr_csr   = wr && hit_csr;
	wire rd_csr   = rd && hit_csr;

	wire ss_int   = select_source_soft ? soft_select_level : ss_s;
	wire selected = !ss_int;

	wire [6:0] half = half_of(rate);
	wire       tick = busy_q && master_select && (div_q == 7'(half - 7'h01));

	wire slv_edge = en && !master_select && selected && (sck_s != sck_s3_q);
	wire edge_ev  = master_select ? tick : slv_edge;
	wire leading  = master_select ? !phase_q : (sck_s != clock_idle_level);
	wire capture  = leading ^ clock_capture_phase;
	wire sin      = master_select ? miso_s : mosi_s;
	wire [7:0] sh_cap = {sh_q[6:0], sin};
	wire fin      = edge_ev && (cnt_q == LAST_EDGE);
	wire [7:0] rx_byte = capture ? sh_cap : sh_q;
	wire in_prog  = busy_q || (cnt_q != 4'h0);

	wire fault    = en && master_select && !ss_int;
	wire wr_block = done_q && !arm_q;
	wire take     = wr_data && !in_prog && !wr_block;
	wire collide  = wr_data && in_prog;
	wire data_acc = (wr_data || rd_data) && arm_q;
	wire mode_fault_flag_clr = wr_ctrl && marm_q;

	assign done_d = fin || (done_q && !data_acc);
	assign arm_d  = rd_csr || (arm_q && !(wr_data || rd_data));
	assign write_collision_flag_d = collide || (write_collision_flag_q && !(rd_data && arm_q));
	assign ovr_d  = (fin && done_q) || (ovr_q && !rd_csr);
	assign mode_fault_flag_d = fault || (mode_fault_flag_q && !mode_fault_flag_clr);
	assign marm_d = (rd_csr && mode_fault_flag_q) || (marm_q && !wr_ctrl);

	// enable and master refused while fault stands
	wire       allow_set = !mode_fault_flag_q || marm_q;
	wire [7:0] ctrl_wr   = {wdata[7], wdata[B_EN] && allow_set, wdata[5],
	                        wdata[B_MASTER_SELECT] && allow_set, wdata[3:0]};
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl)
			ctrl_d = ctrl_wr;
		if (fault) begin
			ctrl_d[B_EN]   = 1'b0;
			ctrl_d[B_MASTER_SELECT] = 1'b0;
		end
	end

	assign cfg_d = wr_csr ? wdata[2:0] : cfg_q;

	always_comb begin
		sh_d  = sh_q;
		out_d = out_q;
		if (take) begin
			sh_d  = wdata;
			out_d = wdata[7];
		end else if (edge_ev && capture) begin
			sh_d = sh_cap;
		end else if (edge_ev) begin
			out_d = sh_q[7];
		end
	end

	always_comb begin
		cnt_d = cnt_q;
		if (fault || !en || (!master_select && !selected))
			cnt_d = 4'h0;
		else if (edge_ev)
			cnt_d = 4'(cnt_q + 4'h1);
	end

	assign busy_d = (fault || fin) ? 1'b0 : (busy_q || (take && master_select && en));

	wire [7:0] csr_rd = {done_q, write_collision_flag_q, ovr_q, mode_fault_flag_q, 1'b0, cfg_q};
	wire [7:0] rd_mux = hit_data ? rxbuf_q :
	                    hit_ctrl ? ctrl_q :
	                    hit_csr  ? csr_rd : 8'h00;

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q <= CTRL_RST;
			cfg_q  <= CSR_RST;
			done_q <= 1'b0;
			write_collision_flag_q <= 1'b0;
			ovr_q  <= 1'b0;
			mode_fault_flag_q <= 1'b0;
			arm_q  <= 1'b0;
			marm_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			cfg_q  <= cfg_d;
			done_q <= done_d;
			write_collision_flag_q <= write_collision_flag_d;
			ovr_q  <= ovr_d;
			mode_fault_flag_q <= mode_fault_flag_d;
			arm_q  <= arm_d;
			marm_q <= marm_d;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sh_q   <= DATA_RST;
			out_q  <= 1'b0;
			cnt_q  <= 4'h0;
			busy_q <= 1'b0;
		end else begin
			sh_q   <= sh_d;
			out_q  <= out_d;
			cnt_q  <= cnt_d;
			busy_q <= busy_d;
		end
	end

	// buffer only loads while done is clear
	always_ff @(posedge clk) begin
		if (rst)
			rxbuf_q <= DATA_RST;
		else if (fin && !done_q)
			rxbuf_q <= rx_byte;
	end

	always_ff @(posedge clk) begin
		if (rst || !busy_q || fault) begin
			div_q   <= 7'h00;
			phase_q <= 1'b0;
		end else if (tick) begin
			div_q   <= 7'h00;
			phase_q <= !phase_q;
		end else begin
			div_q <= 7'(div_q + 7'h01);
		end
	end

	// pins cross from outside: two flops before use
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q     <= 4'hF;
			s2_q     <= 4'hF;
			// matches the synchroniser reset so no false edge follows reset
			sck_s3_q <= 1'b1;
		end else begin
			s1_q     <= {ss_n_in, miso_in, mosi_in, sck_in};
			s2_q     <= s1_q;
			sck_s3_q <= s2_q[0];
		end
	end

	// registered pin drive; enable low means driving
	always_ff @(posedge clk) begin
		if (rst) begin
			sck_out   <= 1'b0;
			sck_oe_n  <= 1'b1;
			mosi_out  <= 1'b0;
			mosi_oe_n <= 1'b1;
			miso_out  <= 1'b0;
			miso_oe_n <= 1'b1;
			irq       <= 1'b0;
			rdata     <= 8'h00;
		end else begin
			sck_out   <= clock_idle_level ^ phase_q;
			sck_oe_n  <= !(en && master_select);
			mosi_out  <= out_q;
			mosi_oe_n <= !(en && master_select && !odis);
			miso_out  <= out_q;
			miso_oe_n <= !(en && !master_select && !odis && selected);
			irq       <= irq_en && (done_q || mode_fault_flag_q || ovr_q);
			rdata     <= rd ? rd_mux : 8'h00;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_fault_seen;
		rd_csr && mode_fault_flag_q && !fault;
	endsequence
	sequence s_ctrl_write;
		!wr_ctrl [*1] ##0 1'b1;
	endsequence

	AST_IRQ: assert property (irq_en && done_q |=> irq)
		else $error("irq missing with done and enable");
	AST_FAULT_EN: assert property (fault |=> !en ##1 !en || mode_fault_flag_clr)
		else $error("enable survived mode fault");
	AST_FAULT_MASTER_SELECT: assert property (fault |=> !master_select && mode_fault_flag_q)
		else $error("master kept after mode fault");
	AST_RATE4: assert property (tick && rate == RATE_DIV4 && cnt_q < 4'hE && $stable(rate)
		|=> !tick ##1 tick)
		else $error("divide by four spacing wrong");
	AST_SLAVE_NOTICK: assert property (!master_select |-> !tick)
		else $error("divider ran in slave mode");
	AST_IDLE: assert property (!busy_q && !$past(busy_q) |=> sck_out == $past(clock_idle_level))
		else $error("sck idle level wrong");
	AST_DONE: assert property (fin |=> done_q [*1] ##0 !busy_q)
		else $error("done not set at end");
	AST_WBLOCK: assert property (wr_data && wr_block |=> $stable(sh_q) || $past(edge_ev))
		else $error("data write not ignored");
	AST_WRITE_COLLISION_FLAG: assert property (wr_data && in_prog |=> write_collision_flag_q)
		else $error("collision not flagged");
	AST_OVR: assert property (fin && done_q |=> ovr_q && $stable(rxbuf_q))
		else $error("overrun wrong");
	AST_MODE_FAULT_FLAG_CLR: assert property (marm_q && wr_ctrl && !fault |=> !mode_fault_flag_q)
		else $error("fault clear sequence failed");
	AST_RXBUF: assert property (fin && !done_q |=> rxbuf_q == $past(rx_byte))
		else $error("read buffer not loaded");
	AST_START: assert property (take && master_select && en && !fault |=> busy_q && cnt_q == 4'h0)
		else $error("master write did not start");

endmodule
`default_nettype wire

/* File: dv/spi_far_slave.sv */
`default_nettype none
module spi_far_slave (
	// serial pins
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       sel_n,
	output logic            miso,
	// mode and reply byte, load toggles to arm
	input  wire logic       clock_idle_level,
	input  wire logic       clock_capture_phase,
	input  wire logic       load,
	input  wire logic [7:0] tx,
	output logic      [7:0] rx
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh;
	initial miso = 1'b1;
	always @(load) begin
		sh = tx;
		miso = clock_capture_phase ? ~tx[7] : tx[7];
	end
	always @(sck) begin
		if (!sel_n) begin
			if ((sck ^ clock_idle_level) ^ clock_capture_phase) begin
				rx = {rx[6:0], mosi};
			end else if (clock_capture_phase) begin
				miso = sh[7];
				sh = sh << 1;
			end else begin
				sh = sh << 1;
				miso = sh[7];
			end
		end
	end
endmodule
`default_nettype wire

/* File: dv/spi_regif_tb.sv */
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; $display("FAIL %0t mismatch", $time); end end
module spi_regif_tb import spi_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, rst = 1, wr = 0, rd = 0, ss_pin = 1, cpl = 0, cph = 0, sel_n = 1, load = 0;
	logic [15:0] addr = '0;
	logic [7:0]  wdata = '0, ptx = '0, got, b, pw;
	logic [2:0]  rt;
	wire logic [7:0] rdata, prx;
	wire logic   irq, sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, pmiso;
	int          failures = 0, tests_run = 0, n, i;
	// released lines fall back to idle level, pull-up or far slave drive
	wire logic   sck = sck_oe_n ? cpl : sck_out;
	wire logic   mosi = mosi_oe_n ? 1'b1 : mosi_out;
	wire logic   miso = miso_oe_n ? pmiso : miso_out;
	always #4 clk = ~clk;
	spi_regif i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.irq(irq), .sck_in(sck), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .mosi_in(mosi),
		.mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso), .miso_out(miso_out),
		.miso_oe_n(miso_oe_n), .ss_n_in(ss_pin));
	spi_far_slave i_far (.sck(sck), .mosi(mosi), .sel_n(sel_n), .miso(pmiso), .clock_idle_level(cpl), .clock_capture_phase(cph),
		.load(load), .tx(ptx), .rx(prx));
	function automatic logic [2:0] rate_of(input int k);
		logic [2:0] t [6] = '{RATE_DIV4, RATE_DIV8, RATE_DIV16, RATE_DIV32, RATE_DIV64, RATE_DIV128};
		return t[k];
	endfunction
	task automatic wreg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic wait_done;
		got = 8'h00;
		for (n = 0; n < 1000 && got[B_DONE] !== 1'b1; n++) rreg(OFS_CSR, got);
	endtask
	task automatic wrap_up;
		if (failures == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		failures++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		b = $urandom(12);
		rreg(OFS_CTRL, got);
		`CHK(got, 8'h00)
		rreg(OFS_CSR, got);
		`CHK(got, 8'h00)
		rreg(16'h0014, got);
		`CHK(got, 8'h00)
		for (i = 0; i < 6; i++) begin
			wreg(OFS_CTRL, 8'h00);
			cph = i[0];
			cpl = i[1];
			rt = rate_of(i);
			b = {1'b1, 1'b1, rt[2], 1'b1, cpl, cph, rt[1:0]};
			wreg(OFS_CTRL, b);
			ptx = $urandom;
			pw = $urandom;
			load = ~load;
			sel_n = 1'b0;
			wreg(OFS_DATA, pw);
			@(sck);
			b[0] = sck;
			@(negedge clk);
			for (n = 0; sck === b[0] && n < 200; n++) @(negedge clk);
			`CHK(n, 2 << i)
			if (i == 2) wreg(OFS_DATA, ~pw);
			wait_done();
			`CHK(got[B_WRITE_COLLISION_FLAG], i == 2)
			`CHK(irq, 1'b1)
			rreg(OFS_DATA, got);
			if (i > 1) `CHK(got, ptx)
			`CHK(prx, pw)
			sel_n = 1'b1;
			rreg(OFS_CSR, got);
			`CHK(got[7:6], 2'b00)
		end
		// done left unread: next data write must not start a byte
		wreg(OFS_CTRL, 8'hD4);
		wreg(OFS_DATA, $urandom);
		// let the byte finish so the second write meets a standing done flag
		repeat (80) @(posedge clk);
		wreg(OFS_DATA, $urandom);
		repeat (6) @(posedge clk);
		`CHK(sck, cpl)
		rreg(OFS_CSR, got);
		`CHK(got, 8'h80)
		rreg(OFS_DATA, got);
		@(posedge clk);
		#1 `CHK(rdata, 8'h00)
		// soft select low while master: fault
		// reserved bit kept clear
		wreg(OFS_CSR, 8'h02);
		repeat (3) @(posedge clk);
		wreg(OFS_CTRL, 8'hD0);
		rreg(OFS_CTRL, got);
		`CHK({got[B_EN], got[B_MASTER_SELECT]}, 2'b00)
		rreg(OFS_CSR, got);
		`CHK(got, 8'h12)
		`CHK(irq, 1'b1)
		wreg(OFS_CSR, 8'h03);
		wreg(OFS_CTRL, 8'h00);
		rreg(OFS_CSR, got);
		`CHK(got, 8'h03)
		`CHK(sck_oe_n, 1'b1)
		wreg(OFS_CTRL, 8'h50);
		wreg(OFS_CSR, 8'h07);
		repeat (2) @(posedge clk);
		#1 `CHK(mosi_oe_n, 1'b1)
		`CHK(sck_oe_n, 1'b0)
		`CHK(miso_oe_n, 1'b1)
		wreg(OFS_CSR, 8'h03);
		repeat (2) @(posedge clk);
		#1 `CHK(mosi_oe_n, 1'b0)
		wrap_up();
	end
endmodule
`default_nettype wire
